// >>> hdl/pimg_pkg.sv
// Purpose: Constants shared by the process image builder and watchdog
// Assumes: 25 MHz system clock, module link scanned as a list of slots
// Notes:   Summary of rules follows
`default_nettype none
package pimg_pkg;
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned WDOG_MS      = 100;
  localparam int unsigned WDOG_CYCLES  = (CLK_HZ / 1000) * WDOG_MS;
  localparam int unsigned BUS_RST_NS   = 1000;
  localparam int unsigned BUS_RST_CYC  = (BUS_RST_NS * 25 + 999) / 1000;
  localparam logic [7:0]  ROUTE_TAIL   = 8'h01;
  localparam int unsigned SLOT_W       = 4;
  localparam int unsigned PTR_W        = 9;
  localparam logic [PTR_W-1:0] PTR_ZERO = 9'h000;
  localparam logic        WORD_ALIGN_MASK = 1'b1;
  typedef enum logic [1:0] {
    SCAN_IDLE  = 2'b00,
    SCAN_BYTE  = 2'b01,
    SCAN_BIT   = 2'b11,
    SCAN_DONE  = 2'b10
  } scan_t;
endpackage
`default_nettype wire

// >>> hdl/pimg_wdog.sv
// Purpose: Real-time telegram watchdog counter
// Assumes: Kick and enable come from the same clock domain
// Notes:   Expired stays set until kicked or disabled
`timescale 1ns/10ps
`default_nettype none
module pimg_wdog #(
  parameter int unsigned LIMIT = pimg_pkg::WDOG_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic kick,
  output logic      expired
);
  logic [31:0] cnt_q;

  // Restart on each telegram, count up to the limit otherwise
  always_ff @(posedge clk) begin
    if (!rst_n || !enable || kick) begin
      cnt_q   <= 32'h0000_0000;
      expired <= 1'b0;
    end else if (cnt_q >= LIMIT - 1) begin
      expired <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  expire_time_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    (cnt_q == LIMIT - 1) && enable && !kick |=> expired)
    else $error("watchdog did not expire at limit");
  kick_clear_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    kick |=> !expired && cnt_q == 32'h0000_0000)
    else $error("kick did not restart watchdog");
endmodule
`default_nettype wire

// >>> hdl/pimg_top.sv
// Purpose: Process image layout, telegram-synchronous bus cycle, watchdog
// Assumes: Module list offered one slot per cycle after a scan request
// Notes:   Telegram, RT-active and bus-reset pins pass a two-stage synchroniser
`timescale 1ns/10ps
`default_nettype none
module pimg_top #(
  parameter int unsigned SLOTS    = 16,
  parameter int unsigned WDOG_CYC = pimg_pkg::WDOG_CYCLES
) (
  input  wire logic                       CLK_SYS,
  input  wire logic                       RST_N,
  input  wire logic                       SCAN_START,
  input  wire logic                       SLOT_VALID,
  input  wire logic                       SLOT_IS_BYTE,
  input  wire logic [pimg_pkg::SLOT_W-1:0] SLOT_IN_BYTES,
  input  wire logic [pimg_pkg::SLOT_W-1:0] SLOT_OUT_BYTES,
  input  wire logic [pimg_pkg::SLOT_W-1:0] SLOT_IN_BITS,
  input  wire logic [pimg_pkg::SLOT_W-1:0] SLOT_OUT_BITS,
  input  wire logic                       SLOT_LAST,
  input  wire logic                       RT_TELEGRAM,
  input  wire logic                       RT_ACTIVE,
  input  wire logic                       NRT_TELEGRAM,
  input  wire logic                       ACCEPT_NONREALTIME_OPTION,
  input  wire logic                       BUS_RESET_CMD,
  input  wire logic [31:0]                IP_ADDR,
  input  wire logic [15:0]                OUT_DATA,
  output logic [15:0]                     OUT_PINS,
  output logic [pimg_pkg::PTR_W-1:0]      IN_BIT_PTR,
  output logic [pimg_pkg::PTR_W-1:0]      OUT_BIT_PTR,
  output logic                            MAP_WR,
  output logic [pimg_pkg::PTR_W-1:0]      MAP_IN_OFS,
  output logic [pimg_pkg::PTR_W-1:0]      MAP_OUT_OFS,
  output logic                            MAP_LITTLE_END,
  output logic                            SCAN_DONE,
  output logic                            BUS_CYCLE,
  output logic                            BUS_RESET,
  output logic                            NRT_PASS,
  output logic                            RT_ERROR,
  output logic [47:0]                     ROUTING_IDENTIFIER
);
  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic [2:0] rt_s1_q, rt_s2_q;
  logic       rt_last_q;
  logic       rst_cmd_last_q;
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rt_s1_q <= 3'h0;
      rt_s2_q <= 3'h0;
    end else begin
      rt_s1_q <= {BUS_RESET_CMD, RT_ACTIVE, RT_TELEGRAM};
      rt_s2_q <= rt_s1_q;
    end
  end
  // Edge detectors only look at the second stage
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rt_last_q      <= 1'b0;
      rst_cmd_last_q <= 1'b0;
    end else begin
      rt_last_q      <= rt_s2_q[0];
      rst_cmd_last_q <= rt_s2_q[2];
    end
  end
  logic rt_pulse, rst_pulse, rt_on;
  assign rt_pulse  = rt_s2_q[0] && !rt_last_q;
  assign rst_pulse = rt_s2_q[2] && !rst_cmd_last_q;
  assign rt_on     = rt_s2_q[1];

  // ------------------------------------------------------------------
  // Image scan: byte modules pass, then bit modules pass
  // ------------------------------------------------------------------
  pimg_pkg::scan_t scan_q;
  logic [pimg_pkg::PTR_W-1:0] in_byte_q, out_byte_q;
  logic [$clog2(SLOTS+1)-1:0] slot_q;
  logic [pimg_pkg::PTR_W-1:0] in_len, out_len;
  // Word alignment: odd byte counts are padded to a whole word
  assign in_len  = pimg_pkg::PTR_W'(SLOT_IN_BYTES)
                 + pimg_pkg::PTR_W'(SLOT_IN_BYTES[0] & pimg_pkg::WORD_ALIGN_MASK);
  assign out_len = pimg_pkg::PTR_W'(SLOT_OUT_BYTES)
                 + pimg_pkg::PTR_W'(SLOT_OUT_BYTES[0] & pimg_pkg::WORD_ALIGN_MASK);

  // Scan state; the list is walked twice so link order is kept per class
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      scan_q <= pimg_pkg::SCAN_IDLE;
    end else begin
      unique case (scan_q)
        pimg_pkg::SCAN_IDLE: if (SCAN_START) scan_q <= pimg_pkg::SCAN_BYTE;
        pimg_pkg::SCAN_BYTE: if (SLOT_VALID && SLOT_LAST)
          scan_q <= pimg_pkg::SCAN_BIT;
        pimg_pkg::SCAN_BIT:  if (SLOT_VALID && SLOT_LAST)
          scan_q <= pimg_pkg::SCAN_DONE;
        pimg_pkg::SCAN_DONE: if (SCAN_START) scan_q <= pimg_pkg::SCAN_BYTE;
      endcase
    end
  end

  // Byte offsets and bit pointers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || (SCAN_START && scan_q != pimg_pkg::SCAN_BYTE
                   && scan_q != pimg_pkg::SCAN_BIT)) begin
      in_byte_q   <= pimg_pkg::PTR_ZERO;
      out_byte_q  <= pimg_pkg::PTR_ZERO;
      IN_BIT_PTR  <= pimg_pkg::PTR_ZERO;
      OUT_BIT_PTR <= pimg_pkg::PTR_ZERO;
      slot_q      <= '0;
    end else if (SLOT_VALID && scan_q == pimg_pkg::SCAN_BYTE) begin
      slot_q <= SLOT_LAST ? '0 : slot_q + 1'b1;
      if (SLOT_IS_BYTE) begin
        in_byte_q  <= in_byte_q + in_len;
        out_byte_q <= out_byte_q + out_len;
      end
      if (SLOT_LAST) begin
        // Bit area begins right after the byte area, in bits
        IN_BIT_PTR  <= (in_byte_q + (SLOT_IS_BYTE ? in_len : '0)) << 3;
        OUT_BIT_PTR <= (out_byte_q + (SLOT_IS_BYTE ? out_len : '0)) << 3;
      end
    end else if (SLOT_VALID && scan_q == pimg_pkg::SCAN_BIT
                 && !SLOT_IS_BYTE) begin
      IN_BIT_PTR  <= IN_BIT_PTR + pimg_pkg::PTR_W'(SLOT_IN_BITS);
      OUT_BIT_PTR <= OUT_BIT_PTR + pimg_pkg::PTR_W'(SLOT_OUT_BITS);
    end
  end

  // Mapping record per placed module
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      MAP_WR         <= 1'b0;
      MAP_IN_OFS     <= pimg_pkg::PTR_ZERO;
      MAP_OUT_OFS    <= pimg_pkg::PTR_ZERO;
      MAP_LITTLE_END <= 1'b1;
      SCAN_DONE      <= 1'b0;
    end else begin
      MAP_LITTLE_END <= 1'b1;
      SCAN_DONE      <= (scan_q == pimg_pkg::SCAN_DONE);
      MAP_WR         <= SLOT_VALID && ((scan_q == pimg_pkg::SCAN_BYTE
                        && SLOT_IS_BYTE) || (scan_q == pimg_pkg::SCAN_BIT
                        && !SLOT_IS_BYTE));
      MAP_IN_OFS     <= (scan_q == pimg_pkg::SCAN_BYTE) ? in_byte_q
                        : IN_BIT_PTR;
      MAP_OUT_OFS    <= (scan_q == pimg_pkg::SCAN_BYTE) ? out_byte_q
                        : OUT_BIT_PTR;
    end
  end

  // ------------------------------------------------------------------
  // Watchdog and error
  // ------------------------------------------------------------------
  logic wd_exp;
  pimg_wdog #(.LIMIT(WDOG_CYC)) u_wdog (
    .clk     (CLK_SYS),
    .rst_n   (RST_N),
    .enable  (rt_on),
    .kick    (rt_pulse),
    .expired (wd_exp)
  );

  // Error flag and zeroed outputs while telegrams are missing
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      RT_ERROR <= 1'b0;
      OUT_PINS <= 16'h0000;
    end else begin
      RT_ERROR <= wd_exp;
      OUT_PINS <= wd_exp ? 16'h0000 : OUT_DATA;
    end
  end

  // Other services pass when option set, RT idle, or watchdog expired
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) NRT_PASS <= 1'b0;
    else NRT_PASS <= NRT_TELEGRAM && (ACCEPT_NONREALTIME_OPTION || !rt_on
                     || wd_exp);
  end

  // ------------------------------------------------------------------
  // Terminal bus cycle and reset
  // ------------------------------------------------------------------
  logic [7:0] brst_q;
  // Cycle strobe rides on every telegram, never free-running; the
  // telegram that ends an error still gets its bus cycle
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) BUS_CYCLE <= 1'b0;
    else BUS_CYCLE <= rt_pulse;
  end
  // Stretch the reset command to a minimum pulse
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      brst_q    <= 8'h00;
      BUS_RESET <= 1'b0;
    end else begin
      if (rst_pulse) brst_q <= 8'(pimg_pkg::BUS_RST_CYC);
      else if (brst_q != 8'h00) brst_q <= brst_q - 8'h01;
      BUS_RESET <= rst_pulse || (brst_q > 8'h01);
    end
  end

  // Routing identifier: address then two bytes of one
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) ROUTING_IDENTIFIER <= 48'h0000_0000_0000;
    else ROUTING_IDENTIFIER <= {IP_ADDR, pimg_pkg::ROUTE_TAIL,
                                pimg_pkg::ROUTE_TAIL};
  end

  bus_cycle_a: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N) rt_pulse |=> BUS_CYCLE)
    else $error("no bus cycle after telegram");
  zero_out_a: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N) wd_exp |=> OUT_PINS == 16'h0000 && RT_ERROR)
    else $error("outputs not zeroed on error");
  nrt_block_a: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    rt_on && !ACCEPT_NONREALTIME_OPTION && !wd_exp |=> !NRT_PASS)
    else $error("non real time passed");
  bus_reset_a: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N) rst_pulse |=> BUS_RESET)
    else $error("bus reset not issued");
  // Skip the first edge after reset, the register still holds zero then
  route_id_a: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N) $past(RST_N)
    |-> ROUTING_IDENTIFIER == {$past(IP_ADDR), 16'h0101})
    else $error("routing identifier wrong");
  little_end_a: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N) MAP_WR |-> MAP_LITTLE_END)
    else $error("byte order not little endian");
  // The last byte slot lands on the edge that enters the bit pass
  byte_first_a: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    scan_q == pimg_pkg::SCAN_BIT && $past(scan_q) == pimg_pkg::SCAN_BIT
    |-> $stable(in_byte_q))
    else $error("byte area grew in bit pass");
  slot_count_a: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    scan_q == pimg_pkg::SCAN_BYTE && SLOT_VALID |-> slot_q < SLOTS)
    else $error("more slots than the link holds");
endmodule
`default_nettype wire

// >>> bench/rt_host.sv
// Purpose: Host controller model sending cyclic real-time telegrams
// Assumes: One task cycle is TASK_CYC system clocks
// Notes:   Telegram held two clocks so the pin synchroniser sees it
`timescale 1ns/10ps
`default_nettype none
module rt_host #(
  parameter int unsigned TASK_CYC = 20,
  parameter int unsigned DIVIDER  = 2,
  parameter int unsigned MODULO   = 1
) (
  input  wire logic clk,
  input  wire logic run,
  output logic      telegram
);
  int unsigned tick_q;
  int unsigned task_q;
  // Task clock; cleared to zero while stopped, like a halted host
  always_ff @(posedge clk) begin
    if (!run) begin
      tick_q <= 0;
      task_q <= 0;
    end else if (tick_q == TASK_CYC - 1) begin
      tick_q <= 0;
      task_q <= (task_q == DIVIDER - 1) ? 0 : task_q + 1;
    end else begin
      tick_q <= tick_q + 1;
    end
  end
  // One telegram per group, in the task at the modulo position
  always_ff @(posedge clk) begin
    telegram <= run && task_q == MODULO && tick_q < 2;
  end
endmodule
`default_nettype wire

// >>> bench/pimg_top_bench.sv
// Purpose: Self-checking bench for the process image and watchdog
// Assumes: Watchdog shortened to 50 clocks; host frame every 40 clocks
// Notes:   Pulse outputs are counted by a monitor, not polled
`timescale 1ns/10ps
`default_nettype none
module pimg_top_bench;
  localparam int unsigned WD = 50;
  logic clk_sys, rst_n, scan, sv, sb, sl, rt_act, nrt, opt, brc, run;
  logic [3:0] sib, sob, sibt, sobt;
  logic [15:0] out_data, out_pins;
  logic [8:0] ibp, obp, mio, moo;
  logic [47:0] rid;
  logic tel, tel_p, brst_p, map_wr, le, done, bcyc, brst, npass, rt_err;
  int err_count, compares, n_bc, n_tel, n_np, n_br, n_brh;
  logic [17:0] ofs_q[$];
  pimg_top #(.SLOTS(4), .WDOG_CYC(WD)) dut_u (.CLK_SYS(clk_sys),
    .RST_N(rst_n), .SCAN_START(scan), .SLOT_VALID(sv), .SLOT_IS_BYTE(sb),
    .SLOT_IN_BYTES(sib), .SLOT_OUT_BYTES(sob), .SLOT_IN_BITS(sibt),
    .SLOT_OUT_BITS(sobt), .SLOT_LAST(sl), .RT_TELEGRAM(tel),
    .RT_ACTIVE(rt_act), .NRT_TELEGRAM(nrt),
    .ACCEPT_NONREALTIME_OPTION(opt), .BUS_RESET_CMD(brc),
    .IP_ADDR(32'hac101142), .OUT_DATA(out_data), .OUT_PINS(out_pins),
    .IN_BIT_PTR(ibp), .OUT_BIT_PTR(obp), .MAP_WR(map_wr), .MAP_IN_OFS(mio),
    .MAP_OUT_OFS(moo), .MAP_LITTLE_END(le), .SCAN_DONE(done),
    .BUS_CYCLE(bcyc), .BUS_RESET(brst), .NRT_PASS(npass), .RT_ERROR(rt_err),
    .ROUTING_IDENTIFIER(rid));
  rt_host host_u (.clk(clk_sys), .run(run), .telegram(tel));
  // Clock, 40 ns period
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Pulse monitor; counting avoids missing one-cycle strobes
  always @(posedge clk_sys) begin
    tel_p <= tel;
    if (tel && !tel_p) n_tel++;
    if (bcyc === 1'b1) n_bc++;
    if (npass === 1'b1) n_np++;
    brst_p <= brst;
    if (brst === 1'b1 && brst_p !== 1'b1) n_br++;
    if (brst === 1'b1) n_brh++;
    if (map_wr === 1'b1) ofs_q.push_back({mio, moo});
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic pulse_nrt();
    @(posedge clk_sys) nrt <= 1'b1;
    @(posedge clk_sys) nrt <= 1'b0;
    tick(6);
  endtask
  // Two byte modules around a digital one: bytes first, then bits
  task automatic t_scan();
    logic [3:0] ib[3] = '{4'h3, 4'h4, 4'h2};
    logic [3:0] ob[3] = '{4'h2, 4'h4, 4'h4};
    int i;
    @(posedge clk_sys) scan <= 1'b1;
    @(posedge clk_sys) scan <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 3; s++) begin
        sv <= 1'b1; sb <= (s != 1); sl <= (s == 2);
        sib <= ib[s]; sob <= ob[s]; sibt <= ib[s]; sobt <= ob[s];
        @(posedge clk_sys);
      end
    end
    sv <= 1'b0;
    sl <= 1'b0;
    for (i = 0; i < 40 && done !== 1'b1; i++) tick(1);
    if (done !== 1'b1) begin
      check(done, 1'b1);
      wrap_up();
    end
    check(ofs_q.size(), 3);
    check(ofs_q[0], {9'h000, 9'h000});
    check(ofs_q[1], {9'h004, 9'h002});
    check(ofs_q[2], {9'h030, 9'h030});
    check({ibp, obp}, {9'h034, 9'h034});
    check(le, 1'b1);
    check(rid, 48'hac1011420101);
    $display("test scan done");
  endtask
  // Cyclic frames keep the watchdog quiet; their loss zeroes outputs
  task automatic t_watchdog(input logic o);
    int i;
    opt <= o;
    rt_act <= 1'b1;
    out_data <= 16'ha5c3;
    run <= 1'b1;
    tick(240);
    check(rt_err, 1'b0);
    check(out_pins, 16'ha5c3);
    i = n_np;
    pulse_nrt();
    check(n_np - i, o);
    run <= 1'b0;
    tick(10);
    check(n_bc, n_tel);
    for (i = 0; i < 3 * WD && rt_err !== 1'b1; i++) tick(1);
    check(rt_err, 1'b1);
    if (rt_err !== 1'b1) wrap_up();
    check(out_pins, 16'h0000);
    i = n_np;
    pulse_nrt();
    check(n_np - i, 1);
    $display("test watchdog done");
  endtask
  // Local-bus reset command gives one terminal bus reset
  task automatic t_bus_reset();
    @(posedge clk_sys) brc <= 1'b1;
    tick(4);
    brc <= 1'b0;
    tick(40);
    check(n_br, 1);
    check(brst, 1'b0);
    check(n_brh, pimg_pkg::BUS_RST_CYC);
    $display("test bus reset done");
  endtask
  // Main sequence
  initial begin
    {rst_n, scan, sv, sb, sl, rt_act, nrt, opt, brc, run} = '0;
    {sib, sob, sibt, sobt, out_data} = '0;
    {err_count, compares, n_bc, n_tel, n_np, n_br, n_brh} = '0;
    {tel_p, brst_p} = 2'b00;
    tick(8);
    rst_n <= 1'b1;
    tick(2);
    t_scan();
    t_watchdog(1'b0);
    t_watchdog(1'b1);
    t_bus_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
